// File: verilog/miim_defs.svh
// Offsets, field positions, reset values and timing counts of the PHY management register set.
// Assumes inclusion by bare name from any file that needs these numbers.
`ifndef MIIM_DEFS_SVH
`define MIIM_DEFS_SVH

// ----------------------------------------------------------------
// Management addressing
// ----------------------------------------------------------------
`define PHYAD_PORT1 5'h01
`define PHYAD_PORT2 5'h02
`define REG_BASIC_CONTROL 5'h00
`define REG_BASIC_STATUS 5'h01
`define REG_ID_UPPER 5'h02
`define REG_ID_LOWER 5'h03
`define REG_ADVERTISE 5'h04
`define REG_PARTNER 5'h05
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define PREAMBLE_ONES 6'h20
`define SELECTOR_8023 5'h01

// ----------------------------------------------------------------
// Byte-wide host map offsets
// ----------------------------------------------------------------
`define HOST_P1_CTRL_A 8'h1C
`define HOST_P1_CTRL_B 8'h1D
`define HOST_P1_STAT_A 8'h1E
`define HOST_P1_STAT_B 8'h1F
`define HOST_P2_CTRL_A 8'h2C
`define HOST_P2_CTRL_B 8'h2D
`define HOST_P2_STAT_A 8'h2E
`define HOST_P2_STAT_B 8'h2F
`define HOST_PHY_ADDR 8'h40

// ----------------------------------------------------------------
// Control byte A (speed, duplex, advertisement) field positions
// ----------------------------------------------------------------
`define CA_AUTONEG_ENABLE 7
`define CA_SPEED100 6
`define CA_FULL_DUPLEX 5
`define CA_PAUSE 4
`define CA_RESET 8'h9F

// ----------------------------------------------------------------
// Control byte B (PHY controls) field positions
// ----------------------------------------------------------------
`define CB_LED_DISABLE 7
`define CB_TX_DISABLE 6
`define CB_AN_RESTART 5
`define CB_FAR_END_DISABLE 4
`define CB_POWER_DOWN 3
`define CB_MDIX_DISABLE 2
`define CB_FORCE_MDI 1
`define CB_RESET 8'h00

// ----------------------------------------------------------------
// Management-word field positions
// ----------------------------------------------------------------
`define BC_SPEED100 13
`define BC_AUTONEG_ENABLE 12
`define BC_POWER_DOWN 11
`define BC_AN_RESTART 9
`define BC_FULL_DUPLEX 8
`define BC_FORCE_MDI 4
`define BC_MDIX_DISABLE 3
`define BC_FAR_END_DISABLE 2
`define BC_TX_DISABLE 1
`define BC_LED_DISABLE 0
`define AD_PAUSE 10
`define STATUS_ABILITY 4'hF

// ----------------------------------------------------------------
// Frame bit counts: read counts in falling, write counts in rising management clock edges
// ----------------------------------------------------------------
`define RD_TA_DRIVE 5'd1
`define RD_LAST_BIT 5'd17
`define RD_RELEASE 5'd18
`define WR_LAST_BIT 5'd17
`define WR_FIRST_DATA 5'd2

`endif

// File: verilog/miim_pkg.sv
// Types shared by the PHY management register set.
// Assumes nothing beyond a SystemVerilog compiler.
package miim_pkg;
	typedef logic [15:0] word_t;
	typedef logic [7:0] byte_t;
	typedef logic [4:0] addr5_t;
	typedef enum logic [2:0] {PRE, START, HDR, RD, WR} frame_state_t;
endpackage

// File: verilog/miim_port_regs.sv
// One copper port's control storage with its management-word and host-byte views.
// Assumes both write strobes are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`include "miim_defs.svh"
module miim_port_regs #(
	parameter bit HAS_FAR_END = 1'b1,
	parameter logic [15:0] ID_UPPER = 16'h0000,
	parameter logic [15:0] ID_LOWER = 16'h0000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mii_we,
	input wire miim_pkg::addr5_t mii_reg,
	input wire miim_pkg::word_t mii_wdata,
	input wire logic host_we_a,
	input wire logic host_we_b,
	input wire miim_pkg::byte_t host_wdata,
	input wire logic link_up,
	input wire logic autoneg_done,
	input wire logic [4:0] partner,
	input wire logic far_end_fault,
	output miim_pkg::byte_t ctrl_a,
	output miim_pkg::byte_t ctrl_b,
	output miim_pkg::word_t mii_rdata
);
	import miim_pkg::*;

	byte_t next_ctrl_a;
	byte_t next_ctrl_b;
	logic fef_mask;

	assign fef_mask = HAS_FAR_END;

	// ----------------------------------------------------------------
	// Control storage
	// ----------------------------------------------------------------
	// Host byte first, management word second, so a clash favours management
	always_comb begin
		next_ctrl_a = ctrl_a;
		next_ctrl_b = ctrl_b;
		if (host_we_a) begin
			next_ctrl_a = host_wdata; // R14 R15 R18
		end
		if (host_we_b) begin
			next_ctrl_b = host_wdata & 8'hFE;
			next_ctrl_b[`CB_FAR_END_DISABLE] = host_wdata[`CB_FAR_END_DISABLE] & fef_mask; // R7
		end
		if (mii_we && mii_reg == `REG_BASIC_CONTROL) begin
			next_ctrl_a[`CA_SPEED100] = mii_wdata[`BC_SPEED100]; // R18
			next_ctrl_a[`CA_AUTONEG_ENABLE] = mii_wdata[`BC_AUTONEG_ENABLE]; // R18
			next_ctrl_a[`CA_FULL_DUPLEX] = mii_wdata[`BC_FULL_DUPLEX]; // R18
			next_ctrl_b[`CB_POWER_DOWN] = mii_wdata[`BC_POWER_DOWN]; // R18
			next_ctrl_b[`CB_AN_RESTART] = mii_wdata[`BC_AN_RESTART]; // R18
			next_ctrl_b[`CB_FORCE_MDI] = mii_wdata[`BC_FORCE_MDI]; // R5
			next_ctrl_b[`CB_MDIX_DISABLE] = mii_wdata[`BC_MDIX_DISABLE]; // R6
			next_ctrl_b[`CB_FAR_END_DISABLE] = mii_wdata[`BC_FAR_END_DISABLE] & fef_mask; // R7
			next_ctrl_b[`CB_TX_DISABLE] = mii_wdata[`BC_TX_DISABLE]; // R18
			next_ctrl_b[`CB_LED_DISABLE] = mii_wdata[`BC_LED_DISABLE]; // R18
		end
		if (mii_we && mii_reg == `REG_ADVERTISE) begin
			next_ctrl_a[`CA_PAUSE] = mii_wdata[`AD_PAUSE]; // R14
			next_ctrl_a[3:0] = mii_wdata[8:5]; // R15
		end
	end

	// Register the control bytes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a <= `CA_RESET;
			ctrl_b <= `CB_RESET;
		end else begin
			ctrl_a <= next_ctrl_a;
			ctrl_b <= next_ctrl_b;
		end
	end

	// ----------------------------------------------------------------
	// Management-word read view
	// ----------------------------------------------------------------
	// Identifier writes land nowhere, so those words stay fixed
	always_comb begin
		mii_rdata = 16'h0000; // R2
		if (mii_reg == `REG_BASIC_CONTROL) begin
			mii_rdata = {2'b00, ctrl_a[`CA_SPEED100], ctrl_a[`CA_AUTONEG_ENABLE],
				ctrl_b[`CB_POWER_DOWN], 1'b0, ctrl_b[`CB_AN_RESTART],
				ctrl_a[`CA_FULL_DUPLEX], 3'b000, ctrl_b[`CB_FORCE_MDI],
				ctrl_b[`CB_MDIX_DISABLE], ctrl_b[`CB_FAR_END_DISABLE],
				ctrl_b[`CB_TX_DISABLE], ctrl_b[`CB_LED_DISABLE]}; // R5 R6 R7 R18
		end else if (mii_reg == `REG_BASIC_STATUS) begin
			mii_rdata = {1'b0, `STATUS_ABILITY, 4'h0, 1'b0, autoneg_done,
				far_end_fault & fef_mask, 1'b1, link_up, 2'b00}; // R8 R9 R10 R11 R12 R19
		end else if (mii_reg == `REG_ID_UPPER) begin
			mii_rdata = ID_UPPER; // R13
		end else if (mii_reg == `REG_ID_LOWER) begin
			mii_rdata = ID_LOWER; // R13
		end else if (mii_reg == `REG_ADVERTISE) begin
			mii_rdata = {5'b00000, ctrl_a[`CA_PAUSE], 1'b0, ctrl_a[3:0], `SELECTOR_8023}; // R14 R15 R20
		end else if (mii_reg == `REG_PARTNER) begin
			mii_rdata = {5'b00000, partner[4], 1'b0, partner[3:0], 5'b00000}; // R16 R17
		end
	end
endmodule

// File: verilog/miim_phy_register_set.sv
// Management register set of the two copper PHY ports, reached by serial management
// frames and by the byte-wide host map.
// Assumes PHY status inputs are on SYS_CLK; MDC, MDIO and the mode strap are asynchronous.
//
// How it works
// R1: Address one answers with port one registers, address two with port two.
// R2: Only register numbers zero to five exist; others read zero, writes dropped.
// R3: Center-side mode exposes only port one, once host programs its address.
// R4: Host byte map reaches the same control and status state.
// R5: Control bit 4 forces MDI, default 0, mirrored at control byte bit 1.
// R6: Control bit 3 disables auto crossover, default 0, mirrored at bit 2.
// R7: Control bit 2 disables far-end fault detection, port one only.
// R8: Status bit 4 shows far-end fault on port one, read-only.
// R9: Status bit 15 always reads zero.
// R10: Status bits 14 to 11 always read one.
// R11: Status bit 3 reads one; bits 10 to 6 and 1 read zero.
// R12: Status bit 0 always reads zero.
// R13: Registers two and three return a fixed identifier; writes ignored.
// R14: Advertisement bit 10 is pause, default one, mirrored at byte bit 4.
// R15: Advertisement bits 8 to 5 writable, default one, mirror bits 3 to 0.
// R16: Partner bit 10 reports partner pause, read-only.
// R17: Partner bits 8 to 5 report partner abilities; bits 4 to 0 zero.
// R18: Remaining control bits writable and mirrored; unsupported bits read zero.
// R19: Status bits 5 and 2 report negotiation done and link up.
// R20: Advertisement selector reads 00001; other reserved bits read zero.
`timescale 1ns/1ps
`include "miim_defs.svh"
module miim_phy_register_set #(
	parameter logic [15:0] ID_UPPER = 16'hA5C3,
	parameter logic [15:0] ID_LOWER = 16'h5A3C
) (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic MDC,
	input wire logic MDIO_IN,
	output logic MDIO_OUT,
	output logic MDIO_OE,
	input wire logic CENTER_MODE,
	input wire miim_pkg::byte_t HOST_ADDR,
	input wire miim_pkg::byte_t HOST_WDATA,
	input wire logic HOST_WE,
	output miim_pkg::byte_t HOST_RDATA,
	input wire logic [1:0] LINK_UP,
	input wire logic [1:0] AUTONEG_DONE,
	input wire logic [9:0] PARTNER_ABILITY,
	input wire logic FAR_END_FAULT,
	output logic [1:0] SPEED_100,
	output logic [1:0] AUTONEG_ENABLE,
	output logic [1:0] FULL_DUPLEX,
	output logic [1:0] POWER_DOWN,
	output logic [1:0] AUTONEG_RESTART,
	output logic [1:0] FORCE_MDI,
	output logic [1:0] MDIX_DISABLE,
	output logic [1:0] TX_DISABLE,
	output logic [1:0] LED_DISABLE,
	output logic [1:0] ADVERTISE_PAUSE,
	output logic [7:0] ADVERTISE_ABILITY,
	output logic FAR_END_DISABLE
);
	import miim_pkg::*;

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic mdc_meta, mdc_sync, mdc_prev;
	logic mdio_meta, mdio_sync, mode_meta, mode_sync;
	logic mdc_rise, mdc_fall;

	// Two flops per asynchronous input, a third for MDC edge finding
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			mdc_meta <= 1'b0;
			mdc_sync <= 1'b0;
			mdc_prev <= 1'b0;
			mdio_meta <= 1'b1;
			mdio_sync <= 1'b1;
			mode_meta <= 1'b0;
			mode_sync <= 1'b0;
		end else begin
			mdc_meta <= MDC;
			mdc_sync <= mdc_meta;
			mdc_prev <= mdc_sync;
			mdio_meta <= MDIO_IN;
			mdio_sync <= mdio_meta;
			mode_meta <= CENTER_MODE;
			mode_sync <= mode_meta;
		end
	end

	// Edges seen three system clocks late; an MDC period of eight clocks leaves margin
	assign mdc_rise = mdc_sync & ~mdc_prev;
	assign mdc_fall = ~mdc_sync & mdc_prev;

	// ----------------------------------------------------------------
	// Per-port register sets
	// ----------------------------------------------------------------
	byte_t ctrl_a [2], ctrl_b [2];
	word_t port_rdata [2];
	logic [1:0] port_we, host_we_a, host_we_b;
	addr5_t frame_reg;
	word_t wr_data;
	logic wr_pulse, wr_port;

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			assign port_we[p] = wr_pulse & (wr_port == 1'(p));
			miim_port_regs #(
				.HAS_FAR_END(p == 0),
				.ID_UPPER(ID_UPPER),
				.ID_LOWER(ID_LOWER)
			) u_regs (
				.clk(SYS_CLK),
				.rst_n(RESETN),
				.mii_we(port_we[p]),
				.mii_reg(frame_reg),
				.mii_wdata(wr_data),
				.host_we_a(host_we_a[p]),
				.host_we_b(host_we_b[p]),
				.host_wdata(HOST_WDATA),
				.link_up(LINK_UP[p]),
				.autoneg_done(AUTONEG_DONE[p]),
				.partner(PARTNER_ABILITY[p*5 +: 5]),
				.far_end_fault(FAR_END_FAULT),
				.ctrl_a(ctrl_a[p]),
				.ctrl_b(ctrl_b[p]),
				.mii_rdata(port_rdata[p])
			);
			// Mirrored control bits drive the PHY straight from storage
			assign SPEED_100[p] = ctrl_a[p][`CA_SPEED100];
			assign AUTONEG_ENABLE[p] = ctrl_a[p][`CA_AUTONEG_ENABLE];
			assign FULL_DUPLEX[p] = ctrl_a[p][`CA_FULL_DUPLEX];
			assign ADVERTISE_PAUSE[p] = ctrl_a[p][`CA_PAUSE];
			assign ADVERTISE_ABILITY[p*4 +: 4] = ctrl_a[p][3:0];
			assign POWER_DOWN[p] = ctrl_b[p][`CB_POWER_DOWN];
			assign AUTONEG_RESTART[p] = ctrl_b[p][`CB_AN_RESTART];
			assign FORCE_MDI[p] = ctrl_b[p][`CB_FORCE_MDI];
			assign MDIX_DISABLE[p] = ctrl_b[p][`CB_MDIX_DISABLE];
			assign TX_DISABLE[p] = ctrl_b[p][`CB_TX_DISABLE];
			assign LED_DISABLE[p] = ctrl_b[p][`CB_LED_DISABLE];
		end
	endgenerate

	assign FAR_END_DISABLE = ctrl_b[0][`CB_FAR_END_DISABLE]; // R7

	// ----------------------------------------------------------------
	// Host byte port
	// ----------------------------------------------------------------
	addr5_t phy_addr, next_phy_addr;
	logic phy_addr_set, next_phy_addr_set;
	byte_t next_host_rdata;

	// Byte offsets of the two ports decode to per-port write strobes
	assign host_we_a[0] = HOST_WE && HOST_ADDR == `HOST_P1_CTRL_A; // R4
	assign host_we_b[0] = HOST_WE && HOST_ADDR == `HOST_P1_CTRL_B; // R4
	assign host_we_a[1] = HOST_WE && HOST_ADDR == `HOST_P2_CTRL_A; // R4
	assign host_we_b[1] = HOST_WE && HOST_ADDR == `HOST_P2_CTRL_B; // R4

	// Read mux; status bytes are live views, unmapped offsets read zero
	always_comb begin
		next_phy_addr = phy_addr;
		next_phy_addr_set = phy_addr_set;
		if (HOST_WE && HOST_ADDR == `HOST_PHY_ADDR) begin
			next_phy_addr = HOST_WDATA[4:0]; // R3
			next_phy_addr_set = 1'b1; // R3
		end
		next_host_rdata = 8'h00;
		if (HOST_ADDR == `HOST_P1_CTRL_A) begin
			next_host_rdata = ctrl_a[0];
		end else if (HOST_ADDR == `HOST_P1_CTRL_B) begin
			next_host_rdata = ctrl_b[0];
		end else if (HOST_ADDR == `HOST_P1_STAT_A) begin
			next_host_rdata = {1'b0, AUTONEG_DONE[0], LINK_UP[0], PARTNER_ABILITY[4:0]}; // R4
		end else if (HOST_ADDR == `HOST_P1_STAT_B) begin
			next_host_rdata = {7'h00, FAR_END_FAULT}; // R8
		end else if (HOST_ADDR == `HOST_P2_CTRL_A) begin
			next_host_rdata = ctrl_a[1];
		end else if (HOST_ADDR == `HOST_P2_CTRL_B) begin
			next_host_rdata = ctrl_b[1];
		end else if (HOST_ADDR == `HOST_P2_STAT_A) begin
			next_host_rdata = {1'b0, AUTONEG_DONE[1], LINK_UP[1], PARTNER_ABILITY[9:5]}; // R4
		end else if (HOST_ADDR == `HOST_PHY_ADDR) begin
			next_host_rdata = {3'b000, phy_addr};
		end
	end

	// Host-side registers
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			phy_addr <= 5'h00;
			phy_addr_set <= 1'b0;
			HOST_RDATA <= 8'h00;
		end else begin
			phy_addr <= next_phy_addr;
			phy_addr_set <= next_phy_addr_set;
			HOST_RDATA <= next_host_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Management frame engine
	// ----------------------------------------------------------------
	frame_state_t state, next_state;
	logic [5:0] ones, next_ones;
	logic [4:0] cnt, next_cnt;
	logic [11:0] hdr, next_hdr;
	word_t shreg, next_shreg, next_wr_data;
	logic next_wr_pulse, next_wr_port, next_mdio_out, next_mdio_oe, match1, match2;
	addr5_t next_frame_reg, hdr_phy;
	logic [1:0] hdr_op;

	// Header arrives as op(2), PHY address(5), register(5); last bit joins here
	assign hdr_op = hdr[10:9];
	assign hdr_phy = hdr[8:4];
	assign match1 = mode_sync ? (phy_addr_set && hdr_phy == phy_addr)
		: (hdr_phy == `PHYAD_PORT1); // R1 R3
	assign match2 = !mode_sync && hdr_phy == `PHYAD_PORT2; // R1 R3

	// A frame aimed elsewhere falls back to preamble hunting, which resyncs
	always_comb begin
		next_state = state;
		next_ones = ones;
		next_cnt = cnt;
		next_hdr = hdr;
		next_shreg = shreg;
		next_wr_pulse = 1'b0;
		next_wr_port = wr_port;
		next_frame_reg = frame_reg;
		next_wr_data = wr_data;
		next_mdio_out = MDIO_OUT;
		next_mdio_oe = MDIO_OE;
		case (state)
			PRE: begin
				if (mdc_rise) begin
					if (mdio_sync) begin
						next_ones = (ones == `PREAMBLE_ONES) ? ones : ones + 6'd1;
					end else if (ones == `PREAMBLE_ONES) begin
						next_state = START;
					end else begin
						next_ones = 6'd0;
					end
				end
			end
			START: begin
				if (mdc_rise) begin
					next_ones = 6'd0;
					next_cnt = 5'd0;
					next_state = mdio_sync ? HDR : PRE;
				end
			end
			HDR: begin
				if (mdc_rise) begin
					next_hdr = {hdr[10:0], mdio_sync};
					next_cnt = cnt + 5'd1;
					if (cnt == 5'd11) begin
						next_frame_reg = {hdr[3:0], mdio_sync};
						next_wr_port = match2;
						next_cnt = 5'd0;
						next_state = PRE;
						if ((match1 || match2) && hdr_op == `OP_READ) begin
							next_state = RD;
						end else if ((match1 || match2) && hdr_op == `OP_WRITE) begin
							next_state = WR;
						end
					end
				end
			end
			RD: begin
				// Word taken at the first fall, after frame_reg settles; bit 15 leaves first
				if (mdc_fall) begin
					next_cnt = cnt + 5'd1;
					if (cnt == 5'd0) begin
						next_shreg = wr_port ? port_rdata[1] : port_rdata[0];
					end else if (cnt == `RD_TA_DRIVE) begin
						next_mdio_oe = 1'b1;
						next_mdio_out = 1'b0;
					end else if (cnt > `RD_TA_DRIVE && cnt <= `RD_LAST_BIT) begin
						next_mdio_out = shreg[15];
						next_shreg = {shreg[14:0], 1'b0};
					end else if (cnt == `RD_RELEASE) begin
						next_mdio_oe = 1'b0;
						next_mdio_out = 1'b1;
						next_state = PRE;
					end
				end
			end
			WR: begin
				// Two turnaround bits are skipped, then sixteen data bits shift in
				if (mdc_rise) begin
					next_cnt = cnt + 5'd1;
					if (cnt >= `WR_FIRST_DATA) begin
						next_shreg = {shreg[14:0], mdio_sync};
					end
					if (cnt == `WR_LAST_BIT) begin
						next_wr_data = {shreg[14:0], mdio_sync};
						next_wr_pulse = 1'b1; // R2 R13
						next_state = PRE;
					end
				end
			end
			default: begin
				next_state = PRE;
			end
		endcase
	end

	// Frame engine registers
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state <= PRE;
			ones <= 6'd0;
			cnt <= 5'd0;
			hdr <= 12'h000;
			shreg <= 16'h0000;
			wr_pulse <= 1'b0;
			wr_port <= 1'b0;
			frame_reg <= 5'h00;
			wr_data <= 16'h0000;
			MDIO_OUT <= 1'b1;
			MDIO_OE <= 1'b0;
		end else begin
			state <= next_state;
			ones <= next_ones;
			cnt <= next_cnt;
			hdr <= next_hdr;
			shreg <= next_shreg;
			wr_pulse <= next_wr_pulse;
			wr_port <= next_wr_port;
			frame_reg <= next_frame_reg;
			wr_data <= next_wr_data;
			MDIO_OUT <= next_mdio_out;
			MDIO_OE <= next_mdio_oe;
		end
	end
endmodule

// File: test/miim_phy_register_set_sva.sv
// Checker for the host byte port and the management data pin of the PHY register set.
// Assumes binding to miim_phy_register_set; all signals are on SYS_CLK.
`timescale 1ns/1ps
module miim_phy_register_set_sva (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic MDIO_OUT,
	input wire logic MDIO_OE,
	input wire miim_pkg::byte_t HOST_ADDR,
	input wire miim_pkg::byte_t HOST_WDATA,
	input wire logic HOST_WE,
	input wire miim_pkg::byte_t HOST_RDATA,
	input wire logic [1:0] LINK_UP,
	input wire logic [1:0] AUTONEG_DONE,
	input wire logic [9:0] PARTNER_ABILITY,
	input wire logic FAR_END_FAULT,
	input wire logic [1:0] SPEED_100,
	input wire logic [1:0] AUTONEG_ENABLE,
	input wire logic [1:0] FULL_DUPLEX,
	input wire logic [1:0] POWER_DOWN,
	input wire logic [1:0] AUTONEG_RESTART,
	input wire logic [1:0] FORCE_MDI,
	input wire logic [1:0] MDIX_DISABLE,
	input wire logic [1:0] TX_DISABLE,
	input wire logic [1:0] LED_DISABLE,
	input wire logic [1:0] ADVERTISE_PAUSE,
	input wire logic [7:0] ADVERTISE_ABILITY,
	input wire logic FAR_END_DISABLE
);
	import miim_pkg::*;
	// One domain, so clock and reset are given once
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	// Host writes reach the control outputs one cycle later
	a_ctrl_a_write: assert property (HOST_WE && HOST_ADDR == 8'h1C |=>
		{AUTONEG_ENABLE[0], SPEED_100[0], FULL_DUPLEX[0], ADVERTISE_PAUSE[0],
		ADVERTISE_ABILITY[3:0]} == $past(HOST_WDATA)) else $error("control byte A not applied");
	a_ctrl_b_write: assert property (HOST_WE && HOST_ADDR == 8'h1D |=>
		{LED_DISABLE[0], TX_DISABLE[0], AUTONEG_RESTART[0], FAR_END_DISABLE, POWER_DOWN[0],
		MDIX_DISABLE[0], FORCE_MDI[0]} == $past(HOST_WDATA[7:1]))
		else $error("control byte B not applied");
	// Port two has no far-end disable, so that output must not move
	a_port2_ctrl: assert property (HOST_WE && HOST_ADDR == 8'h2D |=>
		FORCE_MDI[1] == $past(HOST_WDATA[1]) && MDIX_DISABLE[1] == $past(HOST_WDATA[2])
		&& $stable(FAR_END_DISABLE)) else $error("port two control byte wrong");
	a_status_read: assert property (HOST_ADDR == 8'h1E |=>
		HOST_RDATA == {1'b0, $past(AUTONEG_DONE[0]), $past(LINK_UP[0]),
		$past(PARTNER_ABILITY[4:0])}) else $error("status byte wrong");
	a_fault_read: assert property (HOST_ADDR == 8'h1F |=>
		HOST_RDATA == {7'h00, $past(FAR_END_FAULT)}) else $error("fault byte wrong");
	a_empty_read: assert property (HOST_ADDR == 8'h2F || HOST_ADDR == 8'h00 |=>
		HOST_RDATA == 8'h00) else $error("empty byte not zero");
	a_ctrl_readback: assert property (HOST_ADDR == 8'h1C |=>
		HOST_RDATA == {$past(AUTONEG_ENABLE[0]), $past(SPEED_100[0]), $past(FULL_DUPLEX[0]),
		$past(ADVERTISE_PAUSE[0]), $past(ADVERTISE_ABILITY[3:0])})
		else $error("control byte readback wrong");
	// Turnaround zero holds most of one management clock, jitter allowed
	a_turnaround_zero: assert property ($rose(MDIO_OE) |->
		(MDIO_OE && !MDIO_OUT) [*6]) else $error("turnaround bit not zero");
endmodule

bind miim_phy_register_set miim_phy_register_set_sva miim_phy_register_set_sva_i (
	.SYS_CLK, .RESETN, .MDIO_OUT, .MDIO_OE, .HOST_ADDR, .HOST_WDATA, .HOST_WE, .HOST_RDATA,
	.LINK_UP, .AUTONEG_DONE, .PARTNER_ABILITY, .FAR_END_FAULT, .SPEED_100, .AUTONEG_ENABLE,
	.FULL_DUPLEX, .POWER_DOWN, .AUTONEG_RESTART, .FORCE_MDI, .MDIX_DISABLE, .TX_DISABLE,
	.LED_DISABLE, .ADVERTISE_PAUSE, .ADVERTISE_ABILITY, .FAR_END_DISABLE);

// File: test/miim_master.sv
// Behavioural management master: makes MDC and drives its side of MDIO.
// Assumes the bench resolves MDIO with a pull-up and returns the wire on mdio.
`timescale 1ns/1ps
module miim_master (
	output logic mdc,
	output logic mdo,
	output logic mdo_en,
	input wire logic mdio
);
	// Clock stands low and data is released between frames
	initial begin
		mdc = 1'b0;
		mdo = 1'b1;
		mdo_en = 1'b0;
	end
	// One 400 ns clock; data changes after the fall, wire sampled at the rise
	task automatic tick(output logic smp);
		#200 mdc = 1'b1;
		smp = mdio;
		#200 mdc = 1'b0;
	endtask
	// Whole frame with fresh preamble; a read returns what the wire carried
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		logic s;
		hdr = {32'hFFFFFFFF, 2'b01, op, phy, rg};
		#13;
		mdo_en = 1'b1;
		for (int i = 45; i >= 0; i--) begin
			mdo = hdr[i];
			tick(s);
		end
		if (op == 2'b01) begin
			for (int i = 17; i >= 0; i--) begin
				mdo = (i > 15) ? (i == 17) : wd[i];
				tick(s);
			end
		end else begin
			// Released for turnaround; device answers from here on
			mdo_en = 1'b0;
			tick(s);
			tick(s);
			for (int i = 15; i >= 0; i--) begin
				tick(s);
				rd[i] = s;
			end
		end
		mdo_en = 1'b0;
		#400;
	endtask
endmodule

// File: test/testbench.sv
// Self-checking bench for the PHY management register set.
// Assumes miim_master drives MDC and frames; the bench drives the host byte port.
`timescale 1ns/1ps
module testbench;
	import miim_pkg::*;
	localparam word_t id_upper = 16'hA5C3; // Arbitrary identifier value
	localparam word_t id_lower = 16'h5A3C; // Arbitrary identifier value
	logic SYS_CLK = 1'b0;
	logic RESETN = 1'b0;
	logic mdc, mdo, mdo_en, mdio_wire, MDIO_OUT, MDIO_OE;
	logic CENTER_MODE = 1'b0;
	logic HOST_WE = 1'b0;
	byte_t HOST_ADDR = 8'h00;
	byte_t HOST_WDATA = 8'h00;
	byte_t HOST_RDATA;
	logic [1:0] LINK_UP = 2'b00;
	logic [1:0] AUTONEG_DONE = 2'b00;
	logic [9:0] PARTNER_ABILITY = 10'h000;
	logic FAR_END_FAULT = 1'b0;
	logic [1:0] SPEED_100, AUTONEG_ENABLE, FULL_DUPLEX, POWER_DOWN, AUTONEG_RESTART, FORCE_MDI;
	logic [1:0] MDIX_DISABLE, TX_DISABLE, LED_DISABLE, ADVERTISE_PAUSE;
	logic [7:0] ADVERTISE_ABILITY;
	logic FAR_END_DISABLE;
	int error_cnt = 0;
	int total_checks = 0;
	word_t rd;
	always #25 SYS_CLK = ~SYS_CLK;
	// Pull-up wins when neither side drives, so a silent device reads as ones
	assign mdio_wire = MDIO_OE ? MDIO_OUT : (mdo_en ? mdo : 1'b1);
	miim_phy_register_set #(.ID_UPPER(id_upper), .ID_LOWER(id_lower)) miim_phy_register_set_i (
		.SYS_CLK, .RESETN, .MDC(mdc), .MDIO_IN(mdio_wire), .MDIO_OUT, .MDIO_OE, .CENTER_MODE,
		.HOST_ADDR, .HOST_WDATA, .HOST_WE, .HOST_RDATA, .LINK_UP, .AUTONEG_DONE,
		.PARTNER_ABILITY, .FAR_END_FAULT, .SPEED_100, .AUTONEG_ENABLE, .FULL_DUPLEX,
		.POWER_DOWN, .AUTONEG_RESTART, .FORCE_MDI, .MDIX_DISABLE, .TX_DISABLE, .LED_DISABLE,
		.ADVERTISE_PAUSE, .ADVERTISE_ABILITY, .FAR_END_DISABLE);
	miim_master miim_master_i (.mdc, .mdo, .mdo_en, .mdio(mdio_wire));
	// Shared helpers for comparisons and both access paths
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic mrd(input logic [4:0] phy, input logic [4:0] rg, input word_t exp);
		miim_master_i.frame(2'b10, phy, rg, 16'h0000, rd);
		chk($sformatf("phy %0d reg %0d", phy, rg), exp, rd);
	endtask
	task automatic mwr(input logic [4:0] phy, input logic [4:0] rg, input word_t wd);
		miim_master_i.frame(2'b01, phy, rg, wd, rd);
		@(posedge SYS_CLK);
		#1;
	endtask
	task automatic hwr(input byte_t a, input byte_t d);
		@(posedge SYS_CLK);
		#1 {HOST_WE, HOST_ADDR, HOST_WDATA} = {1'b1, a, d};
		@(posedge SYS_CLK);
		#1 {HOST_WE, HOST_ADDR} = {1'b0, 8'h00};
	endtask
	task automatic hrd(input byte_t a, input byte_t exp);
		@(posedge SYS_CLK);
		#1 HOST_ADDR = a;
		@(posedge SYS_CLK);
		#1 chk($sformatf("host byte %h", a), exp, HOST_RDATA);
		HOST_ADDR = 8'h00;
	endtask
	task automatic t_reset();
		chk("reset enables", 12'hFFF, {AUTONEG_ENABLE, ADVERTISE_PAUSE, ADVERTISE_ABILITY});
		chk("reset controls", 16'h0000, {SPEED_100, FULL_DUPLEX, POWER_DOWN, AUTONEG_RESTART,
			FORCE_MDI, MDIX_DISABLE, TX_DISABLE, LED_DISABLE});
		chk("reset far end", 1'b0, FAR_END_DISABLE);
		mrd(1, 0, 16'h1000);
		mrd(2, 4, 16'h05E1);
		mrd(1, 1, 16'h7808);
		hrd(8'h1C, 8'h9F);
		$display("t_reset done");
	endtask
	task automatic t_status();
		#1 {LINK_UP, AUTONEG_DONE, PARTNER_ABILITY, FAR_END_FAULT} = {4'b0101, 10'h0D9, 1'b1};
		mrd(1, 1, 16'h783C);
		mrd(2, 1, 16'h7808);
		mrd(1, 5, 16'h0520);
		mrd(2, 5, 16'h00C0);
		hwr(8'h1E, 8'hFF);
		hrd(8'h1E, 8'h79);
		hrd(8'h1F, 8'h01);
		#1 FAR_END_FAULT = 1'b0;
		mrd(1, 1, 16'h782C);
		$display("t_status done");
	endtask
	task automatic t_ident();
		for (int p = 1; p <= 2; p++) begin
			mrd(p[4:0], 2, id_upper);
			mrd(p[4:0], 3, id_lower);
		end
		mwr(1, 2, 16'hFFFF);
		mwr(2, 3, 16'h0000);
		mrd(1, 2, id_upper);
		mrd(2, 3, id_lower);
		$display("t_ident done");
	endtask
	task automatic t_control();
		mwr(1, 0, 16'h3B1F);
		chk("port1 controls", 10'h3FF, {SPEED_100[0], AUTONEG_ENABLE[0], POWER_DOWN[0],
			AUTONEG_RESTART[0], FULL_DUPLEX[0], FORCE_MDI[0], MDIX_DISABLE[0],
			FAR_END_DISABLE, TX_DISABLE[0], LED_DISABLE[0]});
		mwr(2, 0, 16'h001C);
		chk("port2 controls", 3'b011, {AUTONEG_ENABLE[1], FORCE_MDI[1], MDIX_DISABLE[1]});
		mrd(2, 0, 16'h0018);
		hrd(8'h1D, 8'hFE);
		hrd(8'h2D, 8'h06);
		hwr(8'h1D, 8'h00);
		hwr(8'h2D, 8'h12);
		hrd(8'h2D, 8'h02);
		mrd(1, 0, 16'h3100);
		$display("t_control done");
	endtask
	task automatic t_advert();
		mwr(2, 4, 16'h0000);
		mrd(2, 4, 16'h0001);
		chk("advertise", 10'h10F, {ADVERTISE_PAUSE, ADVERTISE_ABILITY});
		hwr(8'h2C, 8'h95);
		mrd(2, 4, 16'h04A1);
		hwr(8'h1C, 8'h00);
		hrd(8'h1C, 8'h00);
		mrd(1, 4, 16'h0001);
		$display("t_advert done");
	endtask
	task automatic t_refused();
		mrd(1, 6, 16'h0000);
		mrd(2, 31, 16'h0000);
		mrd(3, 0, 16'hFFFF);
		miim_master_i.frame(2'b11, 1, 0, 16'h0000, rd);
		chk("op 11 frame", 16'hFFFF, rd);
		hrd(8'h2F, 8'h00);
		hrd(8'h55, 8'h00);
		#1 CENTER_MODE = 1'b1;
		mrd(1, 2, 16'hFFFF);
		hwr(8'h40, 8'h07);
		mrd(7, 2, id_upper);
		mrd(2, 2, 16'hFFFF);
		$display("t_refused done");
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence after five cycles of reset
	initial begin
		repeat (5) @(posedge SYS_CLK);
		#1 RESETN = 1'b1;
		repeat (4) @(posedge SYS_CLK);
		t_reset();
		t_status();
		t_ident();
		t_control();
		t_advert();
		t_refused();
		summarize();
	end
	// About 31 frames of 26 us each fit well inside this span
	initial begin
		#3000000;
		error_cnt++;
		summarize();
	end
endmodule
